/* File: mdspi_pkg.sv */
// Package for the gate driver serial port: frame layout, register map, defaults, timing.
// Shared by the device end and the host end.
`default_nettype none
package mdspi_pkg;
  localparam int FRAME_BITS = 16;
  localparam int RW_BIT     = 15;
  localparam int ADDR_HI    = 14;
  localparam int ADDR_LO    = 11;
  localparam int DATA_HI    = 7;
  // Register addresses
  localparam logic [3:0] ADDR_FAULT_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_PER_FET_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MAIN_CONTROL   = 4'h2;
  localparam logic [3:0] ADDR_GATE_WD_CTRL   = 4'h3;
  localparam logic [3:0] ADDR_DRAIN_MON_CTRL = 4'h4;
  localparam logic [3:0] ADDR_CONFIG_CTRL    = 4'h5;
  // Main control fields
  localparam int CLEAR_FAULTS_BIT = 0;
  localparam int LOCK_HI          = 5;
  localparam int LOCK_LO          = 3;
  localparam logic [2:0] LOCK_CODE   = 3'h6;
  localparam logic [2:0] UNLOCK_CODE = 3'h3;
  // Fault status fields
  localparam int ANY_FAULT_BIT = 7;
  // Reset values
  localparam logic [7:0] MAIN_CONTROL_RST = 8'h18;
  localparam logic [7:0] GATE_WD_RST      = 8'h07;
  localparam logic [7:0] DRAIN_MON_RST    = 8'h00;
  localparam logic [7:0] CONFIG_RST       = 8'h00;
  // Host timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int CS_HIGH_MIN_NS  = 500;
  localparam int CS_HIGH_CYCLES  = (CS_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Six clocks a half: the reply crosses two synchronisers each way before the host samples
  localparam int SCLK_HALF_CYC   = 5;
  // Host command port register offsets
  localparam logic [1:0] HREG_COMMAND  = 2'h0;
  localparam logic [1:0] HREG_STATUS   = 2'h1;
  localparam logic [1:0] HREG_RESPONSE = 2'h2;
endpackage
`default_nettype wire

/* File: mdspi_if.sv */
// Serial link between the host master and the driver slave.
// Serial output enable marks the cycles in which the driver end owns sdo.
`timescale 1ns/1ps
`default_nettype none
interface mdspi_if;
  logic chip_select_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  modport device (input chip_select_n, input sclk, input sdi, output sdo, output sdo_oe);
  modport host (output chip_select_n, output sclk, output sdi, input sdo, input sdo_oe);
endinterface
`default_nettype wire

/* File: mdspi_device.sv */
// Driver end: serial slave and the six-register map with fault flags.
// Operation
// - Frame: rw bit, 4-bit address, data byte
// - Write returns register value before write
// - Read returns contents, changes nothing; here a full-length read also clears the frame error
// - Response low byte is data, high meaningless
// - Master uses mode 1, clock idles low
// - Clock low at chip select edges
// - Chip select high 500 ns between frames
// - Deselected: ignore inputs, output three-stated
// - Master gives exactly sixteen clocks
// - Sample on falling edge, drive on rising
// - Most significant bit first
// - Wrong-length write: frame error, no update
// - Clock low at power-up or dummy read
// - Status registers are read only
// - Master never writes reserved addresses
// - Fault status bit order as listed
// - Bit 7 ORs bits 6 to 1
// - Per transistor gate and overcurrent faults
// - Clear faults bit clears status flags
// - Lock 110b, unlock 011b, else nothing
// - Settings default on wake or recovery
// Assumes fault inputs are asynchronous level events from analog monitors.
`timescale 1ns/1ps
`default_nettype none
module mdspi_device
  import mdspi_pkg::*;
(
  // Clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       SYS_RST_I,
  // Settings reset on wake or supply recovery
  input  wire logic       SETTINGS_RST_I,
  // Fault events
  input  wire logic [6:0] FAULT_EVENT_I,
  input  wire logic [7:0] FET_FAULT_EVENT_I,
  // Link
  mdspi_if.device         link,
  // User outputs
  output logic [7:0]      MAIN_CONTROL_O,
  output logic [7:0]      GATE_WD_CTRL_O,
  output logic [7:0]      DRAIN_MON_CTRL_O,
  output logic [7:0]      CONFIG_CTRL_O,
  output logic [7:0]      FAULT_STATUS_O,
  output logic [7:0]      PER_FET_STATUS_O,
  output logic            FRAME_ERROR_O
);
  typedef struct packed {
    logic [2:0]  cs_sync;
    logic [2:0]  sclk_sync;
    logic [1:0]  sdi_sync;
    logic [6:0]  f_meta;
    logic [6:0]  f_sync;
    logic [7:0]  p_meta;
    logic [7:0]  p_sync;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic [5:0]  bit_cnt;
    logic        active;
    logic        sdo;
    logic        sdo_oe;
    logic [6:0]  faults;
    logic [7:0]  fet_faults;
    logic        locked;
    logic [7:0]  main_ctl;
    logic [7:0]  gate_wd;
    logic [7:0]  drain_mon;
    logic [7:0]  config_ctl;
    logic        frame_err;
    logic        rw;
    logic        srst_meta;
    logic        srst_sync;
    logic        any_fault;
  } mdspi_dev_state_type;

  mdspi_dev_state_type s_reg, s_next;

  function automatic logic [7:0] reg_read(input logic [3:0] a, input mdspi_dev_state_type s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_FAULT_STATUS:   v = {s.any_fault, s.faults};
      ADDR_PER_FET_STATUS: v = s.fet_faults;
      ADDR_MAIN_CONTROL:   v = s.main_ctl;
      ADDR_GATE_WD_CTRL:   v = s.gate_wd;
      ADDR_DRAIN_MON_CTRL: v = s.drain_mon;
      ADDR_CONFIG_CTRL:    v = s.config_ctl;
      default:             v = 8'h00;
    endcase
    return v;
  endfunction

  logic       cs_fall, cs_rise, sclk_fall, sclk_rise, cs_low;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       clr;

  always_comb begin
    s_next = s_reg;
    s_next.cs_sync   = {s_reg.cs_sync[1:0], link.chip_select_n};
    s_next.sclk_sync = {s_reg.sclk_sync[1:0], link.sclk};
    s_next.sdi_sync  = {s_reg.sdi_sync[0], link.sdi};
    s_next.f_meta    = FAULT_EVENT_I;
    s_next.f_sync    = s_reg.f_meta;
    s_next.p_meta    = FET_FAULT_EVENT_I;
    s_next.p_sync    = s_reg.p_meta;
    // Wake and recovery come from the analog side, so they are synchronised too
    s_next.srst_meta = SETTINGS_RST_I;
    s_next.srst_sync = s_reg.srst_meta;
    cs_low    = ~s_reg.cs_sync[1];
    cs_fall   = s_reg.cs_sync[2] & ~s_reg.cs_sync[1];
    cs_rise   = ~s_reg.cs_sync[2] & s_reg.cs_sync[1];
    sclk_fall = s_reg.sclk_sync[2] & ~s_reg.sclk_sync[1];
    sclk_rise = ~s_reg.sclk_sync[2] & s_reg.sclk_sync[1];
    addr  = s_reg.shift_in[ADDR_HI:ADDR_LO];
    wdata = s_reg.shift_in[DATA_HI:0];
    clr   = 1'b0;
    if (cs_fall) begin
      s_next.active  = 1'b1;
      s_next.bit_cnt = '0;
      s_next.sdo_oe  = 1'b1;
      s_next.sdo     = 1'b0;
    end else if (s_reg.active && cs_low) begin
      if (sclk_fall) begin
        s_next.shift_in = {s_reg.shift_in[14:0], s_reg.sdi_sync[1]};
        // Keep the first bit: a long frame pushes it out of the shifter, a short one leaves it below bit 15
        if (s_reg.bit_cnt == 6'h00) begin
          s_next.rw = s_reg.sdi_sync[1];
        end
        if (s_reg.bit_cnt != 6'h3F) begin
          s_next.bit_cnt = s_reg.bit_cnt + 6'h01;
        end
        // After the address bits, load the response before data shifts out
        // The last address bit arrives in this cycle, so take it from the input
        if (s_reg.bit_cnt == 6'h04) begin
          s_next.shift_out = {8'h00,
            reg_read({s_reg.shift_in[2:0], s_reg.sdi_sync[1]}, s_reg)};
        end
      end
      if (sclk_rise) begin
        s_next.sdo = s_reg.bit_cnt >= 6'h08 ? s_reg.shift_out[15 - s_reg.bit_cnt[3:0]] : 1'b0;
      end
    end
    if (cs_rise && s_reg.active) begin
      s_next.active = 1'b0;
      s_next.sdo_oe = 1'b0;
      if (s_reg.bit_cnt != 6'(FRAME_BITS)) begin
        // A cut read leaves a pending write error standing
        s_next.frame_err = s_reg.frame_err | ~s_reg.rw;
      end else begin
        s_next.frame_err = 1'b0;
        if (!s_reg.shift_in[RW_BIT]) begin
          case (addr)
            ADDR_MAIN_CONTROL: begin
              // Lock field keeps its code; only the two codes change state
              s_next.main_ctl = {wdata[7:6], s_reg.main_ctl[5:3], wdata[2:0]};
              if (!s_reg.locked && wdata[LOCK_HI:LOCK_LO] == LOCK_CODE) begin
                s_next.locked = 1'b1;
                s_next.main_ctl[LOCK_HI:LOCK_LO] = LOCK_CODE;
              end
              if (s_reg.locked && wdata[LOCK_HI:LOCK_LO] == UNLOCK_CODE) begin
                s_next.locked = 1'b0;
                s_next.main_ctl[LOCK_HI:LOCK_LO] = UNLOCK_CODE;
              end
              clr = wdata[CLEAR_FAULTS_BIT];
              s_next.main_ctl[CLEAR_FAULTS_BIT] = 1'b0;
            end
            ADDR_GATE_WD_CTRL:   if (!s_reg.locked) s_next.gate_wd = wdata;
            ADDR_DRAIN_MON_CTRL: if (!s_reg.locked) s_next.drain_mon = wdata;
            ADDR_CONFIG_CTRL:    if (!s_reg.locked) s_next.config_ctl = wdata;
            default: ;
          endcase
        end
      end
    end
    // Set wins over clear
    s_next.faults     = (clr ? 7'h00 : s_reg.faults) | s_reg.f_sync;
    s_next.fet_faults = (clr ? 8'h00 : s_reg.fet_faults) | s_reg.p_sync;
    s_next.any_fault  = |s_next.faults[6:1];
    if (s_reg.srst_sync) begin
      s_next.main_ctl   = MAIN_CONTROL_RST;
      s_next.gate_wd    = GATE_WD_RST;
      s_next.drain_mon  = DRAIN_MON_RST;
      s_next.config_ctl = CONFIG_RST;
      s_next.locked     = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      s_reg            <= '0;
      s_reg.cs_sync    <= 3'h7;
      s_reg.main_ctl   <= MAIN_CONTROL_RST;
      s_reg.gate_wd    <= GATE_WD_RST;
      s_reg.drain_mon  <= DRAIN_MON_RST;
      s_reg.config_ctl <= CONFIG_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.sdo          = s_reg.sdo;
  assign link.sdo_oe       = s_reg.sdo_oe;
  assign MAIN_CONTROL_O    = s_reg.main_ctl;
  assign GATE_WD_CTRL_O    = s_reg.gate_wd;
  assign DRAIN_MON_CTRL_O  = s_reg.drain_mon;
  assign CONFIG_CTRL_O     = s_reg.config_ctl;
  assign FAULT_STATUS_O    = {s_reg.any_fault, s_reg.faults};
  assign PER_FET_STATUS_O  = s_reg.fet_faults;
  assign FRAME_ERROR_O     = s_reg.frame_err;
endmodule
`default_nettype wire

/* File: mdspi_host.sv */
// Host end: serial master driven from a small command register port.
// Assumes software issues one frame at a time and polls busy.
`timescale 1ns/1ps
`default_nettype none
module mdspi_host
  import mdspi_pkg::*;
(
  // Clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       SYS_RST_I,
  // Register port
  input  wire logic [1:0] ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic [15:0]     RDATA_O,
  // Link
  mdspi_if.host           link
);
  typedef enum logic [1:0] {IDLE, LEAD, SHIFT, GAP} mdspi_hstate_type;
  typedef struct packed {
    mdspi_hstate_type st;
    logic [1:0]  sdo_sync;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [4:0]  bits;
    logic [7:0]  tmr;
    logic        sclk;
    logic        cs_n;
    logic        sdi;
    logic [15:0] rdata;
  } mdspi_host_state_type;

  mdspi_host_state_type s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.sdo_sync = {s_reg.sdo_sync[0], link.sdo};
    s_next.rdata = 16'h0000;
    if (RD_I) begin
      case (ADDR_I)
        HREG_STATUS:   s_next.rdata = {15'h0000, s_reg.st != IDLE};
        HREG_RESPONSE: s_next.rdata = s_reg.rx;
        default:       s_next.rdata = 16'h0000;
      endcase
    end
    case (s_reg.st)
      IDLE: begin
        if (WR_I && ADDR_I == HREG_COMMAND) begin
          s_next.tx   = WDATA_I;
          s_next.cs_n = 1'b0;
          s_next.sdi  = WDATA_I[15];
          s_next.tmr  = 8'(SCLK_HALF_CYC);
          s_next.bits = '0;
          s_next.st   = LEAD;
        end
      end
      LEAD: begin
        s_next.tmr = s_reg.tmr - 8'h01;
        if (s_reg.tmr == 8'h00) begin
          s_next.sclk = 1'b1;
          s_next.tmr  = 8'(SCLK_HALF_CYC);
          s_next.st   = SHIFT;
        end
      end
      SHIFT: begin
        s_next.tmr = s_reg.tmr - 8'h01;
        if (s_reg.tmr == 8'h00) begin
          s_next.tmr = 8'(SCLK_HALF_CYC);
          if (s_reg.sclk) begin
            s_next.sclk = 1'b0;
            s_next.rx   = {s_reg.rx[14:0], s_reg.sdo_sync[1]};
            s_next.bits = s_reg.bits + 5'h01;
          end else if (s_reg.bits == 5'(FRAME_BITS)) begin
            s_next.cs_n = 1'b1;
            s_next.tmr  = 8'(CS_HIGH_CYCLES);
            s_next.st   = GAP;
          end else begin
            s_next.sclk = 1'b1;
            s_next.sdi  = s_reg.tx[15 - s_reg.bits[3:0]];
          end
        end
      end
      GAP: begin
        s_next.tmr = s_reg.tmr - 8'h01;
        if (s_reg.tmr == 8'h00) s_next.st = IDLE;
      end
      default: s_next.st = IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      s_reg      <= '0;
      s_reg.st   <= IDLE;
      s_reg.cs_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.chip_select_n = s_reg.cs_n;
  assign link.sclk          = s_reg.sclk;
  assign link.sdi           = s_reg.sdi;
  assign RDATA_O            = s_reg.rdata;
endmodule
`default_nettype wire

/* File: mdspi_monitor.sv */
// Checker for the serial link between the host end and the driver end.
// Assumes it is instantiated beside the link, on the system clock.
`timescale 1ns/1ps
`default_nettype none
module mdspi_monitor (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // Link
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic [5:0] gap_reg;
  logic [4:0] falls_reg;
  logic       sclk_reg;
  // Saturates so long idle spells never wrap below the gap bound
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      gap_reg   <= 6'h3F;
      falls_reg <= 5'h00;
      sclk_reg  <= 1'b0;
    end else begin
      sclk_reg  <= sclk;
      gap_reg   <= !chip_select_n ? 6'h00 : (gap_reg == 6'h3F ? gap_reg : gap_reg + 6'h01);
      falls_reg <= chip_select_n ? 5'h00 : falls_reg + 5'(sclk_reg && !sclk);
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  property p_oe_off; chip_select_n [*4] |-> !sdo_oe; endproperty
  property p_oe_on; $fell(sclk) |-> sdo_oe; endproperty
  property p_idle_low; chip_select_n |-> !sclk; endproperty
  property p_cs_edge; $changed(chip_select_n) |-> !sclk && !$past(sclk); endproperty
  property p_gap; $fell(chip_select_n) |-> gap_reg >= 6'h14; endproperty
  property p_sixteen; $rose(chip_select_n) |-> falls_reg == 5'h10; endproperty
  property p_sdi_hold; $fell(sclk) |-> $stable(sdi) && sdi == $past(sdi, 2); endproperty
  property p_sdo_hold; $fell(sclk) |-> $stable(sdo); endproperty
  property p_upper; $fell(sclk) && falls_reg < 5'h08 |-> !sdo; endproperty
  a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");
  a_oe_on: assert property (p_oe_on) else $error("sdo not driven in frame");
  a_idle_low: assert property (p_idle_low) else $error("clock high while idle");
  a_cs_edge: assert property (p_cs_edge) else $error("clock high at select edge");
  a_gap: assert property (p_gap) else $error("deselect gap too short");
  a_sixteen: assert property (p_sixteen) else $error("frame not sixteen clocks");
  a_sdi_hold: assert property (p_sdi_hold) else $error("sdi moved near sample");
  a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved at sample");
  a_upper: assert property (p_upper) else $error("upper response byte not zero");
  c_frame: cover property ($rose(chip_select_n) && falls_reg == 5'h10);
  c_data: cover property ($fell(sclk) && sdo);
  c_gap: cover property ($fell(chip_select_n) && gap_reg < 6'h1E);
endmodule
`default_nettype wire

/* File: tb.sv */
// Bench: host and driver ends joined, plus a second driver on a hand-driven link.
// Assumes the host polls busy and the driver updates a few clocks after deselect.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mdspi_pkg::*;
  localparam logic [23:0] ROWS [19] = '{24'h900018, 24'h980007, 24'h205A00, 24'h20A55A,
    24'hA000A5, 24'h00FF00, 24'h800000, 24'h08FF00, 24'hC80000, 24'h2F3C00, 24'hA8003C,
    24'h103018, 24'h28113C, 24'hA8003C, 24'h102830, 24'h900030, 24'h101830, 24'h28113C,
    24'hA80011};
  logic        clk, rst, wr, rd, srst;
  logic [1:0]  addr;
  logic [15:0] wdata, rdata, r;
  logic [6:0]  fev;
  logic [7:0]  ffev, main, gwd, dmc, cfg, dmc2, fst, pst;
  logic        ferr, ferr2;
  int          failures, tests_run, cyc;
  mdspi_if lnk();
  mdspi_if lnk2();
  mdspi_host i_mdspi_host (.CLOCK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .link(lnk.host));
  mdspi_device i_mdspi_device (.CLOCK_I(clk), .SYS_RST_I(rst), .SETTINGS_RST_I(srst),
    .FAULT_EVENT_I(fev), .FET_FAULT_EVENT_I(ffev), .link(lnk.device), .MAIN_CONTROL_O(main),
    .GATE_WD_CTRL_O(gwd), .DRAIN_MON_CTRL_O(dmc), .CONFIG_CTRL_O(cfg), .FAULT_STATUS_O(fst),
    .PER_FET_STATUS_O(pst), .FRAME_ERROR_O(ferr));
  mdspi_device i_mdspi_device_2 (.CLOCK_I(clk), .SYS_RST_I(rst), .SETTINGS_RST_I(srst),
    .FAULT_EVENT_I(fev), .FET_FAULT_EVENT_I(ffev), .link(lnk2.device), .MAIN_CONTROL_O(),
    .GATE_WD_CTRL_O(), .DRAIN_MON_CTRL_O(dmc2), .CONFIG_CTRL_O(), .FAULT_STATUS_O(),
    .PER_FET_STATUS_O(), .FRAME_ERROR_O(ferr2));
  mdspi_monitor i_mdspi_monitor (.CLOCK_I(clk), .SYS_RST_I(rst),
    .chip_select_n(lnk.chip_select_n), .sclk(lnk.sclk), .sdi(lnk.sdi), .sdo(lnk.sdo),
    .sdo_oe(lnk.sdo_oe));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic frame(input logic [15:0] c, output logic [15:0] q);
    logic [15:0] s;
    reg_wr(HREG_COMMAND, c);
    repeat (3) @(posedge clk);
    s = 16'h0001;
    while (s[0] !== 1'b0) reg_rd(HREG_STATUS, s);
    reg_rd(HREG_RESPONSE, q);
    repeat (4) @(posedge clk);
  endtask
  // Second link: clock only inside frames, sdi inverted once released
  task automatic bang(input logic [15:0] c, input int n);
    @(posedge clk) lnk2.chip_select_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk);
      lnk2.sclk <= 1'b1;
      lnk2.sdi <= c[15 - (i % 16)];
      repeat (4) @(posedge clk);
      lnk2.sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    lnk2.chip_select_n <= 1'b1;
    lnk2.sdi <= ~lnk2.sdi;
    repeat (25) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      results();
    end
  end
  initial begin
    {wr, rd, srst} = 3'h0;
    addr = 2'h0;
    wdata = 16'h0000;
    fev = 7'h00;
    ffev = 8'h00;
    rst = 1'b1;
    {lnk2.chip_select_n, lnk2.sclk, lnk2.sdi} = 3'h4;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("reset ctl", {main, gwd}, {MAIN_CONTROL_RST, GATE_WD_RST});
    chk("reset cfg", {dmc, cfg}, {DRAIN_MON_RST, CONFIG_RST});
    chk("reset err", {15'h0000, ferr}, 16'h0000);
    foreach (ROWS[k]) begin
      frame(ROWS[k][23:8], r);
      chk("response", r, {8'h00, ROWS[k][7:0]});
    end
    chk("config port", {8'h00, cfg}, 16'h0011);
    chk("main port", {8'h00, main}, 16'h0018);
    for (int i = 0; i < 7; i++) begin
      fev <= 7'h01 << i;
      repeat (4) @(posedge clk);
      fev <= 7'h00;
      frame(16'h8000, r);
      chk("fault", r, {8'h00, (i > 0), 7'h01 << i});
      chk("fault port", {8'h00, fst}, {8'h00, (i > 0), 7'h01 << i});
      frame(16'h1019, r);
    end
    frame(16'h8000, r);
    chk("cleared", r, 16'h0000);
    chk("cleared port", {8'h00, fst}, 16'h0000);
    ffev <= 8'hA5;
    repeat (4) @(posedge clk);
    ffev <= 8'h00;
    frame(16'h8800, r);
    chk("per fet", r, 16'h00A5);
    chk("per fet port", {8'h00, pst}, 16'h00A5);
    frame(16'h1019, r);
    frame(16'h8800, r);
    chk("per fet clear", r, 16'h0000);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("settings", {main, cfg}, {MAIN_CONTROL_RST, CONFIG_RST});
    chk("settings wd", {gwd, dmc}, {GATE_WD_RST, DRAIN_MON_RST});
    // A command written while the host is busy must be dropped
    reg_wr(HREG_COMMAND, 16'h9800);
    frame(16'h2011, r);
    chk("busy refused", r, {8'h00, GATE_WD_RST});
    frame(16'hA000, r);
    chk("refused write", r, {8'h00, DRAIN_MON_RST});
    bang(16'h2077, 15);
    chk("short write", {7'h00, ferr2, dmc2}, 16'h0100);
    bang(16'h2077, 17);
    chk("long write", {7'h00, ferr2, dmc2}, 16'h0100);
    bang(16'h2077, 16);
    chk("good write", {7'h00, ferr2, dmc2}, 16'h0077);
    results();
  end
endmodule
`default_nettype wire
